// File: verilog/urd_pkg.sv
/*
  Constants and carrier types for the UART register decoder.
  Assumes one clock, a synchronous active-high reset and byte registers.
*/
package urd_pkg;

  localparam logic [3:0] OFS_HOLD       = 4'h0;
  localparam logic [3:0] OFS_INT_EN     = 4'h1;
  localparam logic [3:0] OFS_STAT       = 4'h2;
  localparam logic [3:0] OFS_LINE_CTL   = 4'h3;
  localparam logic [3:0] OFS_MODEM_CTL  = 4'h4;
  localparam logic [3:0] OFS_LINE_STAT  = 4'h5;
  localparam logic [3:0] OFS_MODEM_STAT = 4'h6;
  localparam logic [3:0] OFS_SCRATCH    = 4'h7;
  localparam logic [3:0] OFS_TX_LEVEL   = 4'h8;
  localparam logic [3:0] OFS_RX_LEVEL   = 4'h9;
  localparam logic [3:0] OFS_GPIO_DIR   = 4'ha;
  localparam logic [3:0] OFS_GPIO_PIN   = 4'hb;
  localparam logic [3:0] OFS_IOINTEN    = 4'hc;
  localparam logic [3:0] OFS_RSVD       = 4'hd;
  localparam logic [3:0] OFS_IOCTL      = 4'he;
  localparam logic [3:0] OFS_EXTRA      = 4'hf;

  localparam logic [7:0] LINE_CTL_KEY   = 8'hbf;
  localparam int         DIV_SEL_BIT    = 7;
  localparam int         ENH_ON_BIT     = 4;
  localparam int         ALT_SEL_BIT    = 2;
  localparam logic [7:0] RST_BYTE       = 8'h00;

  typedef enum logic [2:0] {
    BANK_NORM = 3'b001,
    BANK_DIV  = 3'b010,
    BANK_ENH  = 3'b100
  } urd_bank_t;

  typedef struct packed {
    logic [3:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } urd_req_t;

  typedef struct packed {
    logic [7:0] rx_byte;
    logic [7:0] int_status;
    logic [7:0] line_status;
    logic [7:0] modem_status;
    logic [7:0] tx_fifo_level;
    logic [7:0] rx_fifo_level;
  } urd_stat_t;

  typedef struct packed {
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] divisor_fraction;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] line_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] enhanced_function;
    logic [7:0] flow_resume_char_1;
    logic [7:0] flow_resume_char_2;
    logic [7:0] flow_pause_char_1;
    logic [7:0] flow_pause_char_2;
    logic [7:0] scratch_pad;
    logic [7:0] transmission_control;
    logic [7:0] trigger_level;
    logic [7:0] gpio_direction;
    logic [7:0] gpio_out;
    logic [7:0] gpio_int_enable;
    logic [7:0] gpio_control;
    logic [7:0] extra_features_control;
  } urd_ctrl_t;

endpackage

// File: verilog/urd_regs.sv
/*
  Register decoder and register file of a single-channel UART.
  Assumes a host port engine that presents one byte access per cycle and
  UART core logic that supplies status bytes and consumes the controls.
*/
// Functional notes
// - Normal bank offset 0: read gives receive byte, write loads transmit.
// - Divisor bank offsets 0 and 1 reach divisor low and high, read/write.
// - Divisor bank offset 2 reaches fraction only when enhanced bit set.
// - Normal bank offset 2: read gives interrupt status, write FIFO control.
// - Normal bank offset 1 reaches interrupt enable, read/write.
// - Offset 3 reaches line control in every bank.
// - Offset 4 reaches modem control unless line control holds key.
// - Offset 5 reads line status outside the key bank; writes there then change nothing.
// - Offset 6 reads modem status by default, read-only.
// - Offset 7 reaches scratch byte by default; read returns last write.
// - Halt/resume and trigger registers share offsets 6 and 7 alternately.
// - Offsets 8 and 9 read transmit and receive FIFO fill levels.
// - Offsets a, b, c, e reach GPIO registers; d is reserved.
// - Offset f reaches extra features control.
// - Key bank offset 2 reaches enhanced function register.
// - Key bank offsets 4 and 5 hold resume characters.
// - Key bank offsets 6 and 7 hold pause characters.
`timescale 1ns/1ps

module urd_regs (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire urd_pkg::urd_req_t req,
  input  wire urd_pkg::urd_stat_t stat,
  input  wire logic [7:0]        gpio_pins,
  output urd_pkg::urd_ctrl_t     ctl_q,
  output logic [7:0]             rdata_q,
  output logic                   rd_ack_q,
  output logic                   tx_load_q,
  output logic                   fifo_ctl_wr_q,
  output logic [7:0]             evt_data_q,
  output logic                   rx_pop_q,
  output logic                   modem_stat_rd_q
);

  urd_pkg::urd_ctrl_t ctl_d;
  urd_pkg::urd_bank_t bank;
  logic [7:0]         rdata_d;
  logic               rd_ack_d;
  logic               tx_load_d;
  logic               fifo_ctl_wr_d;
  logic [7:0]         evt_data_d;
  logic               rx_pop_d;
  logic               modem_stat_rd_d;
  logic               alt_sel;
  logic               enh_on;
  logic [7:0]         gp_s1_q;
  logic [7:0]         gp_s2_q;
  logic [7:0]         gp_s3_q;
  logic [7:0]         gp_q;
  logic [7:0]         gp_d;

  // Bank follows the live line control value, so a bank switch takes
  // effect on the access right after the line control write.
  always_comb begin
    if (ctl_q.line_control_reg == urd_pkg::LINE_CTL_KEY) begin
      bank = urd_pkg::BANK_ENH;
    end else if (ctl_q.line_control_reg[urd_pkg::DIV_SEL_BIT]) begin
      bank = urd_pkg::BANK_DIV;
    end else begin
      bank = urd_pkg::BANK_NORM;
    end
  end

  assign enh_on  = ctl_q.enhanced_function[urd_pkg::ENH_ON_BIT];
  assign alt_sel = ctl_q.modem_control_reg[urd_pkg::ALT_SEL_BIT]
                   & enh_on;

  // Pin filter: a bit changes only when stages two and three agree
  always_comb begin
    gp_d = (~(gp_s2_q ^ gp_s3_q) & gp_s2_q) | ((gp_s2_q ^ gp_s3_q) & gp_q);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      gp_s1_q <= urd_pkg::RST_BYTE;
      gp_s2_q <= urd_pkg::RST_BYTE;
      gp_s3_q <= urd_pkg::RST_BYTE;
      gp_q    <= urd_pkg::RST_BYTE;
    end else if (ce) begin
      gp_s1_q <= gpio_pins;
      gp_s2_q <= gp_s1_q;
      gp_s3_q <= gp_s2_q;
      gp_q    <= gp_d;
    end
  end

  function automatic logic [7:0] read_value(
    input logic [3:0]         a,
    input urd_pkg::urd_bank_t b
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      urd_pkg::OFS_HOLD: begin
        if (b == urd_pkg::BANK_NORM) begin
          v = stat.rx_byte;
        end else if (b == urd_pkg::BANK_DIV) begin
          v = ctl_q.divisor_low;
        end
      end
      urd_pkg::OFS_INT_EN: begin
        if (b == urd_pkg::BANK_NORM) begin
          v = ctl_q.interrupt_enable_reg;
        end else if (b == urd_pkg::BANK_DIV) begin
          v = ctl_q.divisor_high;
        end
      end
      urd_pkg::OFS_STAT: begin
        if (b == urd_pkg::BANK_NORM) begin
          v = stat.int_status;
        end else if (b == urd_pkg::BANK_DIV) begin
          v = enh_on ? ctl_q.divisor_fraction : 8'h00;
        end else begin
          v = ctl_q.enhanced_function;
        end
      end
      urd_pkg::OFS_LINE_CTL: v = ctl_q.line_control_reg;
      urd_pkg::OFS_MODEM_CTL: begin
        v = (b == urd_pkg::BANK_ENH) ? ctl_q.flow_resume_char_1
                                     : ctl_q.modem_control_reg;
      end
      urd_pkg::OFS_LINE_STAT: begin
        v = (b == urd_pkg::BANK_ENH) ? ctl_q.flow_resume_char_2
                                     : stat.line_status;
      end
      urd_pkg::OFS_MODEM_STAT: begin
        if (b == urd_pkg::BANK_ENH) begin
          v = ctl_q.flow_pause_char_1;
        end else if (alt_sel) begin
          v = ctl_q.transmission_control;
        end else begin
          v = stat.modem_status;
        end
      end
      urd_pkg::OFS_SCRATCH: begin
        if (b == urd_pkg::BANK_ENH) begin
          v = ctl_q.flow_pause_char_2;
        end else if (alt_sel) begin
          v = ctl_q.trigger_level;
        end else begin
          v = ctl_q.scratch_pad;
        end
      end
      urd_pkg::OFS_TX_LEVEL: v = stat.tx_fifo_level;
      urd_pkg::OFS_RX_LEVEL: v = stat.rx_fifo_level;
      urd_pkg::OFS_GPIO_DIR: v = ctl_q.gpio_direction;
      urd_pkg::OFS_GPIO_PIN: v = gp_q;
      urd_pkg::OFS_IOINTEN:  v = ctl_q.gpio_int_enable;
      urd_pkg::OFS_IOCTL:    v = ctl_q.gpio_control;
      urd_pkg::OFS_EXTRA:    v = ctl_q.extra_features_control;
      default:              v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    ctl_d         = ctl_q;
    rdata_d       = rdata_q;
    rd_ack_d      = 1'b0;
    tx_load_d     = 1'b0;
    fifo_ctl_wr_d = 1'b0;
    evt_data_d    = evt_data_q;
    rx_pop_d      = 1'b0;
    modem_stat_rd_d = 1'b0;
    if (req.wr) begin
      case (req.addr)
        urd_pkg::OFS_HOLD: begin
          if (bank == urd_pkg::BANK_NORM) begin
            tx_load_d  = 1'b1;
            evt_data_d = req.wdata;
          end else if (bank == urd_pkg::BANK_DIV) begin
            ctl_d.divisor_low = req.wdata;
          end
        end
        urd_pkg::OFS_INT_EN: begin
          if (bank == urd_pkg::BANK_NORM) begin
            ctl_d.interrupt_enable_reg = req.wdata;
          end else if (bank == urd_pkg::BANK_DIV) begin
            ctl_d.divisor_high = req.wdata;
          end
        end
        urd_pkg::OFS_STAT: begin
          if (bank == urd_pkg::BANK_NORM) begin
            fifo_ctl_wr_d = 1'b1;
            evt_data_d    = req.wdata;
          end else if (bank == urd_pkg::BANK_DIV) begin
            if (enh_on) begin
              ctl_d.divisor_fraction = req.wdata;
            end
          end else begin
            ctl_d.enhanced_function = req.wdata;
          end
        end
        urd_pkg::OFS_LINE_CTL: ctl_d.line_control_reg = req.wdata;
        urd_pkg::OFS_MODEM_CTL: begin
          if (bank == urd_pkg::BANK_ENH) begin
            ctl_d.flow_resume_char_1 = req.wdata;
          end else begin
            ctl_d.modem_control_reg = req.wdata;
            // Selector bit is locked unless enhanced functions are on
            if (!enh_on) begin
              ctl_d.modem_control_reg[urd_pkg::ALT_SEL_BIT] =
                ctl_q.modem_control_reg[urd_pkg::ALT_SEL_BIT];
            end
          end
        end
        urd_pkg::OFS_LINE_STAT: begin
          if (bank == urd_pkg::BANK_ENH) begin
            ctl_d.flow_resume_char_2 = req.wdata;
          end
        end
        urd_pkg::OFS_MODEM_STAT: begin
          if (bank == urd_pkg::BANK_ENH) begin
            ctl_d.flow_pause_char_1 = req.wdata;
          end else if (alt_sel) begin
            ctl_d.transmission_control = req.wdata;
          end
        end
        urd_pkg::OFS_SCRATCH: begin
          if (bank == urd_pkg::BANK_ENH) begin
            ctl_d.flow_pause_char_2 = req.wdata;
          end else if (alt_sel) begin
            ctl_d.trigger_level = req.wdata;
          end else begin
            ctl_d.scratch_pad = req.wdata;
          end
        end
        urd_pkg::OFS_GPIO_DIR: ctl_d.gpio_direction = req.wdata;
        urd_pkg::OFS_GPIO_PIN: ctl_d.gpio_out = req.wdata;
        urd_pkg::OFS_IOINTEN:  ctl_d.gpio_int_enable = req.wdata;
        urd_pkg::OFS_IOCTL:    ctl_d.gpio_control = req.wdata;
        urd_pkg::OFS_EXTRA: begin
          ctl_d.extra_features_control = req.wdata;
        end
        default: begin
        end
      endcase
    end
    if (req.rd) begin
      // Read data reflects the state before a same-cycle write
      rd_ack_d = 1'b1;
      rdata_d  = read_value(req.addr, bank);
      rx_pop_d = (req.addr == urd_pkg::OFS_HOLD)
                 && (bank == urd_pkg::BANK_NORM);
      modem_stat_rd_d = (req.addr == urd_pkg::OFS_MODEM_STAT)
                        && (bank != urd_pkg::BANK_ENH) && !alt_sel;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_q         <= '0;
      rdata_q       <= urd_pkg::RST_BYTE;
      rd_ack_q      <= 1'b0;
      tx_load_q     <= 1'b0;
      fifo_ctl_wr_q <= 1'b0;
      evt_data_q    <= urd_pkg::RST_BYTE;
      rx_pop_q      <= 1'b0;
      modem_stat_rd_q <= 1'b0;
    end else if (ce) begin
      ctl_q         <= ctl_d;
      rdata_q       <= rdata_d;
      rd_ack_q      <= rd_ack_d;
      tx_load_q     <= tx_load_d;
      fifo_ctl_wr_q <= fifo_ctl_wr_d;
      evt_data_q    <= evt_data_d;
      rx_pop_q      <= rx_pop_d;
      modem_stat_rd_q <= modem_stat_rd_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_scr_wr;
    ce && req.wr && !req.rd && req.addr == urd_pkg::OFS_SCRATCH
      && bank != urd_pkg::BANK_ENH && !alt_sel;
  endsequence

  // The host leaves one quiet cycle between a write and the next read
  sequence s_bus_idle;
    ce && !req.wr && !req.rd;
  endsequence

  sequence s_scr_rd;
    ce && req.rd && !req.wr && req.addr == urd_pkg::OFS_SCRATCH
      && bank != urd_pkg::BANK_ENH && !alt_sel;
  endsequence

  a_tx_load: assert property (
    ce && req.wr && req.addr == urd_pkg::OFS_HOLD
      && bank == urd_pkg::BANK_NORM
    |=> tx_load_q && evt_data_q == $past(req.wdata))
    else $error("transmit load missing");

  a_rx_read: assert property (
    ce && req.rd && req.addr == urd_pkg::OFS_HOLD
      && bank == urd_pkg::BANK_NORM
    |=> rx_pop_q && rdata_q == $past(stat.rx_byte))
    else $error("receive byte read wrong");

  a_div_low: assert property (
    ce && req.wr && req.addr == urd_pkg::OFS_HOLD
      && bank == urd_pkg::BANK_DIV
    |=> ctl_q.divisor_low == $past(req.wdata) && !tx_load_q)
    else $error("divisor low not written");

  a_frac_gate: assert property (
    ce && req.wr && req.addr == urd_pkg::OFS_STAT
      && bank == urd_pkg::BANK_DIV && !enh_on
    |=> $stable(ctl_q.divisor_fraction))
    else $error("fraction written while locked");

  a_fifo_ctl_write: assert property (
    ce && req.wr && req.addr == urd_pkg::OFS_STAT
      && bank == urd_pkg::BANK_NORM
    |=> fifo_ctl_wr_q && $stable(ctl_q.enhanced_function))
    else $error("FIFO control write wrong");

  a_line_ctl_any: assert property (
    ce && req.wr && req.addr == urd_pkg::OFS_LINE_CTL
    |=> ctl_q.line_control_reg == $past(req.wdata))
    else $error("line control not written");

  a_line_stat_ro: assert property (
    ce && req.rd && req.addr == urd_pkg::OFS_LINE_STAT
      && bank != urd_pkg::BANK_ENH
    |=> rdata_q == $past(stat.line_status))
    else $error("line status read wrong");

  a_scratch_back: assert property (
    s_scr_wr ##1 s_bus_idle ##1 s_scr_rd |=> rdata_q == $past(req.wdata, 3))
    else $error("scratch readback wrong");

  a_enh_key: assert property (
    ce && req.wr && req.addr == urd_pkg::OFS_STAT
      && bank == urd_pkg::BANK_ENH
    |=> ctl_q.enhanced_function == $past(req.wdata) && !fifo_ctl_wr_q)
    else $error("enhanced function not written");

  a_rsvd_zero: assert property (
    ce && req.rd && req.addr == urd_pkg::OFS_RSVD
    |=> rd_ack_q && rdata_q == 8'h00 && !rx_pop_q && !modem_stat_rd_q)
    else $error("reserved read not zero");

endmodule

// File: dv/urd_host.sv
/*
  Host model: issues one-byte accesses on the decoder's request port.
  Assumes the decoder takes a strobe at a rising edge and answers a read
  one cycle later with rd_ack_q and rdata_q.
*/
`timescale 1ns/1ps

module urd_host (
  input  wire logic         clk,
  output urd_pkg::urd_req_t req,
  input  wire logic [7:0]   rdata_q,
  input  wire logic         rd_ack_q
);

  initial begin
    req <= '0;
  end

  // Strobe for one edge; data is scrambled after it so a stale byte is seen
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    req.wr    <= 1'b0;
    req.wdata <= ~d;
    #1;
  endtask

  // Answer is fixed at one cycle, so it is taken just after the edge
  task automatic rd(input  logic [3:0] a,
                    output logic [7:0] d,
                    output logic       ack);
    @(posedge clk);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~req.wdata};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    ack = rd_ack_q;
    d   = rdata_q;
  endtask

endmodule

// File: dv/uart_register_address_decode_test.sv
/*
  Self-checking bench for the UART register decoder.
  Assumes the host model in urd_host.sv and fixed status bytes from here.
*/
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module uart_register_address_decode_test;
  logic               clk;
  logic               reset;
  logic               ce;
  urd_pkg::urd_req_t  req;
  urd_pkg::urd_stat_t stat;
  logic [7:0]         gpio_pins;
  urd_pkg::urd_ctrl_t ctl_q;
  logic [7:0]         rdata_q;
  logic               rd_ack_q;
  logic               tx_load_q;
  logic               fifo_ctl_wr_q;
  logic [7:0]         evt_data_q;
  logic               rx_pop_q;
  logic               modem_stat_rd_q;
  int                 fails;
  int                 num_checks;
  logic [7:0]         rv;
  logic               ack;

  // Normal bank after reset: status bytes pass through, the rest read zero
  localparam logic [7:0] RST_EXP [16] = '{8'ha1, 8'h00, 8'ha2, 8'h00,
    8'h00, 8'ha5, 8'ha6, 8'h00, 8'ha8, 8'ha9, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  localparam logic [3:0] RW_OFS [7] = '{4'h1, 4'h4, 4'h7, 4'ha, 4'hc,
    4'he, 4'hf};
  localparam logic [3:0] RO_OFS [5] = '{4'h5, 4'h6, 4'h8, 4'h9, 4'hd};

  urd_regs urd_regs_inst (
    .clk           (clk),
    .reset         (reset),
    .ce            (ce),
    .req           (req),
    .stat          (stat),
    .gpio_pins     (gpio_pins),
    .ctl_q         (ctl_q),
    .rdata_q       (rdata_q),
    .rd_ack_q      (rd_ack_q),
    .tx_load_q     (tx_load_q),
    .fifo_ctl_wr_q (fifo_ctl_wr_q),
    .evt_data_q    (evt_data_q),
    .rx_pop_q      (rx_pop_q),
    .modem_stat_rd_q (modem_stat_rd_q)
  );

  urd_host urd_host_inst (
    .clk      (clk),
    .req      (req),
    .rdata_q  (rdata_q),
    .rd_ack_q (rd_ack_q)
  );

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    urd_host_inst.wr(a, d);
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    urd_host_inst.rd(a, rv, ack);
    `CHK(ack, 1'b1)
    `CHK(rv, e)
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // A hang is cut short well above the length of the sequence
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    summarize();
  end

  initial begin
    reset     <= 1'b1;
    ce        <= 1'b1;
    gpio_pins <= 8'h00;
    stat = '{8'ha1, 8'ha2, 8'ha5, 8'ha6, 8'ha8, 8'ha9};
    fails      = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      chk_rd(i[3:0], RST_EXP[i]);
    end
    chk_rd(4'h0, 8'ha1);
    `CHK(rx_pop_q, 1'b1)
    chk_rd(4'h6, 8'ha6);
    `CHK(modem_stat_rd_q, 1'b1)
    `CHK(rx_pop_q, 1'b0)
    wr(4'h0, 8'h3c);
    `CHK(tx_load_q, 1'b1)
    `CHK(evt_data_q, 8'h3c)
    wr(4'h2, 8'hc7);
    `CHK(fifo_ctl_wr_q, 1'b1)
    `CHK(tx_load_q, 1'b0)
    `CHK(evt_data_q, 8'hc7)
    chk_rd(4'h2, 8'ha2);
    // Bit 2 of the modem control pattern 8'h4b is clear so the alternate select stays off
    for (int j = 0; j < 7; j++) begin
      wr(RW_OFS[j], {RW_OFS[j], ~RW_OFS[j]});
      chk_rd(RW_OFS[j], {RW_OFS[j], ~RW_OFS[j]});
    end
    for (int j = 0; j < 5; j++) begin
      wr(RO_OFS[j], 8'hff);
      chk_rd(RO_OFS[j], RST_EXP[RO_OFS[j]]);
    end
    wr(4'hb, 8'h99);
    `CHK(ctl_q.gpio_out, 8'h99)
    @(posedge clk);
    gpio_pins <= 8'h5e;
    repeat (6) @(posedge clk);
    chk_rd(4'hb, 8'h5e);
    wr(4'h3, 8'h83);
    chk_rd(4'h3, 8'h83);
    wr(4'h0, 8'h12);
    wr(4'h1, 8'h34);
    chk_rd(4'h0, 8'h12);
    chk_rd(4'h1, 8'h34);
    `CHK(ctl_q.divisor_low, 8'h12)
    wr(4'h2, 8'h56);
    chk_rd(4'h2, 8'h00);
    chk_rd(4'h4, 8'h4b);
    wr(4'h3, 8'hbf);
    chk_rd(4'h3, 8'hbf);
    wr(4'h2, 8'h10);
    chk_rd(4'h2, 8'h10);
    for (int k = 4; k < 8; k++) begin
      wr(k[3:0], 8'h60 + k[7:0]);
      chk_rd(k[3:0], 8'h60 + k[7:0]);
    end
    chk_rd(4'h1, 8'h00);
    `CHK(ctl_q.modem_control_reg, 8'h4b)
    wr(4'h3, 8'h80);
    wr(4'h2, 8'h56);
    chk_rd(4'h2, 8'h56);
    wr(4'h3, 8'h03);
    wr(4'h4, 8'h04);
    chk_rd(4'h4, 8'h04);
    wr(4'h6, 8'h9d);
    wr(4'h7, 8'h8e);
    chk_rd(4'h6, 8'h9d);
    chk_rd(4'h7, 8'h8e);
    `CHK(ctl_q.transmission_control, 8'h9d)
    wr(4'h4, 8'h00);
    chk_rd(4'h6, 8'ha6);
    chk_rd(4'h7, 8'h78);
    // A write offered while the enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(4'h7, 8'h11);
    @(posedge clk);
    ce <= 1'b1;
    chk_rd(4'h7, 8'h78);
    summarize();
  end

endmodule
